//--- src/heat_trace_pkg.sv
// constants, register map and types for the heat-trace circuit controller
package heat_trace_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned SLOT_MS        = 10;
  localparam int unsigned SLOT_CYCLES    = CLK_HZ / 1000 * SLOT_MS;
  localparam int unsigned SSR_PERIOD_S   = 1;
  localparam int unsigned SLOTS_PER_SEC  = 1000 / SLOT_MS;
  localparam int unsigned SEC_PER_MIN    = 60;
  localparam int unsigned SEC_PER_HOUR   = 3600;
  localparam int unsigned MECH_WINDOW_MIN = 20;
  localparam int unsigned RAMP_S         = 90;
  localparam int unsigned RAMP_STEP_SLOTS = RAMP_S * SLOTS_PER_SEC / 100;
  // limits
  localparam logic [15:0] RTD_OHM_MAX    = 16'd313;
  localparam logic [15:0] RTD_OHM_MIN    = 16'd48;
  localparam logic [6:0]  PCT_FULL       = 7'd100;
  localparam logic [6:0]  PCT_MIN_ON     = 7'd8;
  localparam logic [32:0] ACC_LIMIT      = 33'h080000000;
  localparam logic [7:0]  GF_CAP_MIN     = 8'd20;
  localparam logic [7:0]  HC_CAP_MIN     = 8'd1;
  localparam logic [7:0]  HC_CAP_MAX     = 8'd100;
  localparam int unsigned ADDR_MIN       = 1;
  localparam int unsigned ADDR_MAX       = 20;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CLAMP  = 8'h04;
  localparam logic [7:0] REG_MAINT  = 8'h08;
  localparam logic [7:0] REG_MAXT   = 8'h0c;
  localparam logic [7:0] REG_MINAMB = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_AHOUR  = 8'h18;
  localparam logic [7:0] REG_WHOUR  = 8'h1c;
  localparam logic [7:0] REG_GFCAP  = 8'h20;
  localparam logic [7:0] REG_HCCAP  = 8'h24;
  localparam logic [7:0] REG_ADDR   = 8'h28;
  localparam logic [7:0] REG_CLEAR  = 8'h2c;
  localparam logic [7:0] REG_TEMPS  = 8'h30;
  // status field positions
  localparam int unsigned ST_HEAT_BIT  = 0;
  localparam int unsigned ST_FAULT_LSB = 8;
  localparam int unsigned ST_MIN_LSB   = 16;
  localparam int unsigned ST_DUTY_LSB  = 24;
  // clear register bits
  localparam int unsigned CLR_AH_BIT = 0;
  localparam int unsigned CLR_WH_BIT = 1;
  // reset values and bus response codes
  localparam logic [6:0]  CLAMP_RST = 7'd100;
  localparam logic [15:0] MAINT_RST = 16'd5;
  localparam logic [15:0] MAXT_RST  = 16'd15;
  localparam logic [15:0] MINAMB_RST = 16'hffd8;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_ONOFF     = 2'h0,
    MODE_SOFT      = 2'h1,
    MODE_PROP_LINE = 2'h2,
    MODE_PROP_AMB  = 2'h3
  } mode_t;

  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_RAMP = 3'b010,
    ST_FULL = 3'b100
  } heat_st_t;
endpackage : heat_trace_pkg

//--- src/heat_trace_ctrl.sv
// heat-trace circuit control: rtd select, control modes, relay drive, totals
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module heat_trace_ctrl
  import heat_trace_pkg::*;
#(
  parameter int unsigned N_RTD            = 2,
  parameter int unsigned SLOT_CYC         = SLOT_CYCLES,
  parameter bit          RELAY_ELECTROMECH = 1'b0,
  parameter int unsigned HEATER_VOLTS     = 240,
  parameter int unsigned BOARD_ADDR       = 1
) (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                RESET_N,
  // axi4-lite write
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [7:0]          AWADDR,
  input  wire logic                WVALID,
  output logic                     WREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  output logic                     BVALID,
  input  wire logic                BREADY,
  output logic [1:0]               BRESP,
  // axi4-lite read
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  input  wire logic [7:0]          ARADDR,
  output logic                     RVALID,
  input  wire logic                RREADY,
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP,
  // measurements
  input  wire logic [N_RTD*16-1:0] RTD_OHMS,
  input  wire logic [N_RTD*16-1:0] RTD_TEMP,
  input  wire logic [7:0]          HEATER_AMPS,
  input  wire logic [7:0]          LEAK_MA,
  input  wire logic                GF_TRIP,
  input  wire logic                HC_TRIP,
  // outputs
  output logic                     HEATER_ON,
  output logic [N_RTD-1:0]         RTD_FAULT
);

  if (N_RTD < 1 || N_RTD > 8 || SLOT_CYC < 1 || HEATER_VOLTS > 1000 ||
      BOARD_ADDR < ADDR_MIN || BOARD_ADDR > ADDR_MAX) begin : g_chk
    $error("heat_trace_ctrl: parameter out of range");
  end

  localparam logic [31:0] SLOT_LAST = 32'(SLOT_CYC - 1);
  localparam logic [6:0]  SEC_LAST  = 7'(SLOTS_PER_SEC * SSR_PERIOD_S - 1);
  localparam logic [5:0]  MIN_LAST  = 6'(SEC_PER_MIN - 1);
  localparam logic [4:0]  WIN_LAST  = 5'(MECH_WINDOW_MIN - 1);
  localparam logic [6:0]  RAMP_LAST = 7'(RAMP_STEP_SLOTS - 1);

  // percent of full power: 100 at or below lo, 0 at or above hi
  function automatic logic [6:0] pct(input logic signed [15:0] t,
                                     input logic signed [15:0] lo,
                                     input logic signed [15:0] hi);
    logic signed [17:0] num;
    logic signed [17:0] den;
    logic [24:0]        q;
    num = 18'(hi) - 18'(t);
    den = 18'(hi) - 18'(lo);
    q   = '0;
    if (t <= lo) begin
      pct = PCT_FULL;
    end else if (t >= hi || den <= 0) begin
      pct = '0;
    end else begin
      q   = (25'(unsigned'(num)) * 25'(PCT_FULL)) / 25'(unsigned'(den));
      pct = q[6:0];
    end
  endfunction : pct

  // saturating add of whole hours to a running total
  function automatic logic [31:0] sat_add(input logic [31:0] acc,
                                          input logic [31:0] inc);
    logic [32:0] s;
    s = {1'b0, acc} + {1'b0, inc};
    sat_add = (s > ACC_LIMIT) ? ACC_LIMIT[31:0] : s[31:0];
  endfunction : sat_add

  // register state
  mode_t       mode_q;
  logic [6:0]  clamp_q;
  logic [15:0] maint_q, maxt_q, minamb_q;
  logic [31:0] ah_q, wh_q;
  logic [11:0] as_q;
  logic [31:0] ws_q;
  logic [7:0]  gf_cap_q, hc_cap_q;
  // timebase and control state
  logic [31:0] slot_cnt_q;
  logic [6:0]  slot_q;
  logic [5:0]  sec_q;
  logic [4:0]  min_q;
  logic [6:0]  ramp_cnt_q;
  logic [6:0]  ss_duty_q;
  logic [6:0]  per_duty_q;
  logic [4:0]  on_min_q;
  heat_st_t    st_q;
  // axi state
  logic        aw_got_q, w_got_q;
  logic [7:0]  waddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // rtd fault and selection
  logic                     any_ok;
  logic signed [15:0]       t_ctl, t_alm;
  always_comb begin
    any_ok = 1'b0;
    t_ctl  = '0;
    t_alm  = '0;
    for (int i = 0; i < N_RTD; i++) begin
      RTD_FAULT[i] = RTD_OHMS[i*16 +: 16] > RTD_OHM_MAX ||
                     RTD_OHMS[i*16 +: 16] < RTD_OHM_MIN;
      if (!RTD_FAULT[i]) begin
        if (!any_ok || $signed(RTD_TEMP[i*16 +: 16]) < t_ctl) begin
          t_ctl = $signed(RTD_TEMP[i*16 +: 16]);
        end
        if (!any_ok || $signed(RTD_TEMP[i*16 +: 16]) > t_alm) begin
          t_alm = $signed(RTD_TEMP[i*16 +: 16]);
        end
        any_ok = 1'b1;
      end
    end
  end

  logic tick_slot, tick_per, tick_sec, tick_min, tick_win;
  assign tick_slot = slot_cnt_q == SLOT_LAST;
  assign tick_per  = tick_slot && slot_q == SEC_LAST;
  assign tick_sec  = tick_per;
  assign tick_min  = tick_sec && sec_q == MIN_LAST;
  assign tick_win  = tick_min && min_q == WIN_LAST;

  // soft start only with solid-state switch and clamp below full
  logic soft_on;
  assign soft_on = mode_q == MODE_SOFT && !RELAY_ELECTROMECH &&
                   clamp_q < PCT_FULL;
  logic at_maint, at_max;
  assign at_maint = t_ctl <= $signed(maint_q);
  assign at_max   = t_ctl >= $signed(maxt_q);

  // on/off and soft-start state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= ST_OFF;
    end else if (!any_ok || mode_q[1]) begin
      st_q <= ST_OFF;
    end else begin
      unique case (st_q)
        ST_OFF:  if (at_maint) st_q <= soft_on ? ST_RAMP : ST_FULL;
        ST_RAMP: if (at_max) st_q <= ST_OFF;
                 else if (ss_duty_q >= PCT_FULL) st_q <= ST_FULL;
        ST_FULL: if (at_max) st_q <= ST_OFF;
        default: st_q <= ST_OFF;
      endcase
    end
  end

  // ramp from clamp to full, one percent per step
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ss_duty_q  <= '0;
      ramp_cnt_q <= '0;
    end else if (st_q != ST_RAMP) begin
      ss_duty_q  <= clamp_q;
      ramp_cnt_q <= '0;
    end else if (tick_slot) begin
      ramp_cnt_q <= (ramp_cnt_q == RAMP_LAST) ? '0 : ramp_cnt_q + 7'd1;
      if (ramp_cnt_q == RAMP_LAST && ss_duty_q < PCT_FULL) begin
        ss_duty_q <= ss_duty_q + 7'd1;
      end
    end
  end

  // demanded duty
  logic [6:0] prop_d, demand_d;
  always_comb begin
    if (mode_q == MODE_PROP_AMB) begin
      prop_d = pct(t_ctl, minamb_q, maint_q);
    end else begin
      prop_d = pct(t_ctl, maint_q, maxt_q);
    end
    if (prop_d != '0 && prop_d < PCT_MIN_ON) begin
      prop_d = PCT_MIN_ON;
    end
    if (!any_ok) begin
      demand_d = '0;
    end else if (mode_q[1]) begin
      demand_d = prop_d;
    end else begin
      unique case (st_q)
        ST_RAMP: demand_d = ss_duty_q;
        ST_FULL: demand_d = PCT_FULL;
        default: demand_d = '0;
      endcase
    end
    if (!RELAY_ELECTROMECH && demand_d > clamp_q && mode_q != MODE_ONOFF) begin
      demand_d = clamp_q;
    end
    if (mode_q == MODE_SOFT && demand_d > ss_duty_q && st_q == ST_RAMP) begin
      demand_d = ss_duty_q;
    end
    if (mode_q == MODE_SOFT && st_q == ST_FULL) begin
      demand_d = any_ok ? PCT_FULL : '0;
    end
  end

  // timebase
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      slot_cnt_q <= '0;
      slot_q     <= '0;
      sec_q      <= '0;
      min_q      <= '0;
    end else begin
      slot_cnt_q <= tick_slot ? '0 : slot_cnt_q + 32'd1;
      if (tick_slot) slot_q <= (slot_q == SEC_LAST) ? '0 : slot_q + 7'd1;
      if (tick_sec) sec_q <= (sec_q == MIN_LAST) ? '0 : sec_q + 6'd1;
      if (tick_min) min_q <= (min_q == WIN_LAST) ? '0 : min_q + 5'd1;
    end
  end

  // period and window latching
  logic [11:0] on_min_w;
  assign on_min_w = (12'(demand_d) * 12'(MECH_WINDOW_MIN) + 12'd50) / 12'd100;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      per_duty_q <= '0;
      on_min_q   <= '0;
    end else begin
      if (tick_per) per_duty_q <= demand_d;
      if (tick_win) on_min_q <= on_min_w[4:0];
    end
  end

  // relay drive
  logic heat_d;
  always_comb begin
    if (!any_ok) begin
      heat_d = 1'b0;
    end else if (RELAY_ELECTROMECH && mode_q[1]) begin
      heat_d = min_q < on_min_q;
    end else if (RELAY_ELECTROMECH || !soft_on && !mode_q[1]) begin
      heat_d = st_q == ST_FULL;
    end else begin
      heat_d = slot_q < per_duty_q;
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) HEATER_ON <= 1'b0;
    else          HEATER_ON <= heat_d;
  end

  logic [4:0] min_left;
  assign min_left = (RELAY_ELECTROMECH && mode_q[1] && !HEATER_ON) ?
                    5'(MECH_WINDOW_MIN) - min_q : '0;

  // axi write capture and response
  logic wr_go, clr_ah, clr_wh;
  assign AWREADY = !aw_got_q && !BVALID;
  assign WREADY  = !w_got_q && !BVALID;
  assign wr_go   = aw_got_q && w_got_q && !BVALID;
  assign clr_ah  = wr_go && waddr_q == REG_CLEAR && wstrb_q[0] &&
                   wdata_q[CLR_AH_BIT];
  assign clr_wh  = wr_go && waddr_q == REG_CLEAR && wstrb_q[0] &&
                   wdata_q[CLR_WH_BIT];
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      waddr_q  <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
      BVALID   <= 1'b0;
      BRESP    <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got_q <= 1'b1;
        waddr_q  <= {AWADDR[7:2], 2'b00};
      end
      if (WVALID && WREADY) begin
        w_got_q <= 1'b1;
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        BVALID   <= 1'b1;
        BRESP    <= (waddr_q > REG_TEMPS) ? RESP_SLVERR : RESP_OKAY;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // writable settings
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q   <= MODE_ONOFF;
      clamp_q  <= CLAMP_RST;
      maint_q  <= MAINT_RST;
      maxt_q   <= MAXT_RST;
      minamb_q <= MINAMB_RST;
    end else if (wr_go) begin
      unique case (waddr_q)
        REG_CTRL:  if (wstrb_q[0]) mode_q <= mode_t'(wdata_q[1:0]);
        REG_CLAMP: if (wstrb_q[0]) clamp_q <= (wdata_q[6:0] > PCT_FULL) ?
                                              PCT_FULL : wdata_q[6:0];
        REG_MAINT: begin
          if (wstrb_q[0]) maint_q[7:0]  <= wdata_q[7:0];
          if (wstrb_q[1]) maint_q[15:8] <= wdata_q[15:8];
        end
        REG_MAXT: begin
          if (wstrb_q[0]) maxt_q[7:0]  <= wdata_q[7:0];
          if (wstrb_q[1]) maxt_q[15:8] <= wdata_q[15:8];
        end
        REG_MINAMB: begin
          if (wstrb_q[0]) minamb_q[7:0]  <= wdata_q[7:0];
          if (wstrb_q[1]) minamb_q[15:8] <= wdata_q[15:8];
        end
        default: ;
      endcase
    end
  end

  // energy totals, per second
  logic [12:0] as_sum;
  logic [31:0] ws_sum;
  assign as_sum = 13'(as_q) + 13'(HEATER_AMPS);
  assign ws_sum = ws_q + 32'(HEATER_VOLTS) * 32'(HEATER_AMPS);
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      as_q <= '0;
      ah_q <= '0;
    end else if (clr_ah) begin
      as_q <= '0;
      ah_q <= '0;
    end else if (tick_sec) begin
      as_q <= 12'(as_sum % 13'(SEC_PER_HOUR));
      ah_q <= sat_add(ah_q, 32'(as_sum / 13'(SEC_PER_HOUR)));
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ws_q <= '0;
      wh_q <= '0;
    end else if (clr_wh) begin
      ws_q <= '0;
      wh_q <= '0;
    end else if (tick_sec) begin
      ws_q <= ws_sum % 32'(SEC_PER_HOUR);
      wh_q <= sat_add(wh_q, ws_sum / 32'(SEC_PER_HOUR));
    end
  end

  // trip captures
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      gf_cap_q <= '0;
      hc_cap_q <= '0;
    end else begin
      if (GF_TRIP) begin
        gf_cap_q <= (LEAK_MA < GF_CAP_MIN) ? GF_CAP_MIN : LEAK_MA;
      end
      if (HC_TRIP) begin
        hc_cap_q <= (HEATER_AMPS < HC_CAP_MIN) ? HC_CAP_MIN :
                    (HEATER_AMPS > HC_CAP_MAX) ? HC_CAP_MAX :
                    HEATER_AMPS;
      end
    end
  end

  // axi read
  logic [31:0] rd_d;
  logic [31:0] status_w;
  always_comb begin
    status_w = '0;
    status_w[ST_HEAT_BIT] = HEATER_ON;
    status_w[ST_FAULT_LSB +: N_RTD] = RTD_FAULT;
    status_w[ST_MIN_LSB +: 5] = min_left;
    status_w[ST_DUTY_LSB +: 7] = demand_d;
    unique case ({ARADDR[7:2], 2'b00})
      REG_CTRL:   rd_d = 32'(mode_q);
      REG_CLAMP:  rd_d = 32'(clamp_q);
      REG_MAINT:  rd_d = 32'(maint_q);
      REG_MAXT:   rd_d = 32'(maxt_q);
      REG_MINAMB: rd_d = 32'(minamb_q);
      REG_STATUS: rd_d = status_w;
      REG_AHOUR:  rd_d = ah_q;
      REG_WHOUR:  rd_d = wh_q;
      REG_GFCAP:  rd_d = 32'(gf_cap_q);
      REG_HCCAP:  rd_d = 32'(hc_cap_q);
      REG_ADDR:   rd_d = 32'(BOARD_ADDR);
      REG_TEMPS:  rd_d = {t_alm, t_ctl};
      default:    rd_d = '0;
    endcase
  end
  assign ARREADY = !RVALID;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RVALID <= 1'b0;
      RDATA  <= '0;
      RRESP  <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= rd_d;
      RRESP  <= (ARADDR > REG_TEMPS + 8'd3) ? RESP_SLVERR : RESP_OKAY;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

endmodule : heat_trace_ctrl

//--- verif/heat_trace_ctrl_sva.sv
// checker for heat_trace_ctrl bus handshakes, sensor faults and relay drive
`timescale 1ns/1ps
module heat_trace_ctrl_sva
  import heat_trace_pkg::*;
#(
  parameter int unsigned N_RTD = 2
) (
  // clock and reset
  input wire logic               CLK,
  input wire logic               RESET_N,
  // register bus
  input wire logic               AWVALID,
  input wire logic               AWREADY,
  input wire logic               WVALID,
  input wire logic               WREADY,
  input wire logic               BVALID,
  input wire logic               BREADY,
  input wire logic [1:0]         BRESP,
  input wire logic               ARVALID,
  input wire logic               ARREADY,
  input wire logic [7:0]         ARADDR,
  input wire logic               RVALID,
  input wire logic               RREADY,
  input wire logic [31:0]        RDATA,
  input wire logic [1:0]         RRESP,
  // sensors and relay
  input wire logic [N_RTD*16-1:0] RTD_OHMS,
  input wire logic               HEATER_ON,
  input wire logic [N_RTD-1:0]   RTD_FAULT
);
  logic [10:0] dead_q;

  // cycles with every sensor faulted
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) dead_q <= '0;
    else if (!(&RTD_FAULT)) dead_q <= '0;
    else if (dead_q != 11'h7ff) dead_q <= dead_q + 11'h1;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_FAULT_LVL: assert property (RTD_FAULT[0] ==
    (RTD_OHMS[15:0] > RTD_OHM_MAX || RTD_OHMS[15:0] < RTD_OHM_MIN))
    else $error("sensor fault flag wrong");
  AST_DEAD_OFF: assert property (dead_q > 11'd1000 |-> !HEATER_ON)
    else $error("heater on with no healthy sensor");
  AST_RD_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read not answered");
  AST_RD_HOLD: assert property (RVALID && !RREADY |=>
    RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read answer dropped or changed");
  AST_WR_ANSWER: assert property
    (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
    else $error("write not answered");
  AST_B_HOLD: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer dropped or changed");
  AST_RD_BLOCK: assert property (RVALID |-> !ARREADY)
    else $error("read taken while answer pending");
  AST_WR_BLOCK: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while answer pending");
  AST_RD_UNMAPPED: assert property (ARVALID && ARREADY && ARADDR > 8'h33 |=>
    RRESP == RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read answer wrong");
  AST_RD_OK: assert property (ARVALID && ARREADY && ARADDR <= 8'h30 |=>
    RRESP == RESP_OKAY)
    else $error("mapped read refused");

  cover property ($rose(HEATER_ON));
  cover property (dead_q > 11'd1000);
  cover property (ARVALID && ARREADY && ARADDR > 8'h33);
  cover property (BVALID && !BREADY);
endmodule : heat_trace_ctrl_sva

bind heat_trace_ctrl heat_trace_ctrl_sva #(.N_RTD(N_RTD)) chk (
  .CLK(CLK), .RESET_N(RESET_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
  .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
  .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
  .RTD_OHMS(RTD_OHMS), .HEATER_ON(HEATER_ON), .RTD_FAULT(RTD_FAULT)
);

//--- verif/testbench.sv
// self-checking bench for heat_trace_ctrl
`timescale 1ns/1ps
module testbench;
  import heat_trace_pkg::*;
  typedef struct {string nm; logic [31:0] v; logic [31:0] m;} note_t;
  logic        CLK, RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, HEATER_ON;
  logic        GF_TRIP, HC_TRIP;
  logic [7:0]  AWADDR, ARADDR, HEATER_AMPS, LEAK_MA;
  logic [31:0] WDATA, RDATA, RTD_OHMS, RTD_TEMP, last;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, RTD_FAULT;
  note_t       q[$];
  int          error_cnt, checked, seed, n, k, ta, tb;
  int oh[4] = '{47, 48, 313, 314};
  int md[8] = '{2, 2, 2, 2, 3, 3, 3, 3};
  int tp[8] = '{50, 95, 100, -5, 0, 38, 40, -50};
  int du[8] = '{50, 8, 0, 100, 50, 8, 0, 100};
  int lk[3] = '{5, 200, 255};
  int lx[3] = '{20, 200, 255};
  int am[3] = '{150, 0, 50};
  int ax[3] = '{100, 1, 50};

  heat_trace_ctrl #(.SLOT_CYC(4)) dut (
    .CLK(CLK), .RESET_N(RESET_N), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .ARADDR(ARADDR),
    .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RTD_OHMS(RTD_OHMS), .RTD_TEMP(RTD_TEMP), .HEATER_AMPS(HEATER_AMPS),
    .LEAK_MA(LEAK_MA), .GF_TRIP(GF_TRIP), .HC_TRIP(HC_TRIP),
    .HEATER_ON(HEATER_ON), .RTD_FAULT(RTD_FAULT)
  );

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : check

  task guard;
    n++;
    if (n > 2000) begin
      error_cnt++;
      $display("BAD wait exp %h seen %h", 1, 0);
      tally_and_finish;
    end
  endtask : guard

  // bus write, response expected from the address
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    q.push_back('{"bresp", {30'h0, a > 8'h30 ? RESP_SLVERR : RESP_OKAY}, 3});
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID && !BREADY) BREADY <= 1'b1;
      guard;
    end while (!(BVALID && BREADY));
    BREADY <= 1'b0;
  endtask : wr

  // bus read, expectation noted for the watcher
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    repeat (3) @(posedge CLK);
    q.push_back('{$sformatf("reg %h", a), e, m});
    ARADDR <= a;
    ARVALID <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID && !RREADY) RREADY <= 1'b1;
      guard;
    end while (!(RVALID && RREADY));
    last = RDATA;
    RREADY <= 1'b0;
  endtask : rd

  task pop(input logic [31:0] s);
    note_t e;
    if (q.size() == 0) begin
      error_cnt++;
      $display("BAD queue exp %h seen %h", 0, s);
    end else begin
      e = q.pop_front();
      check(e.nm, s & e.m, e.v);
    end
  endtask : pop

  // watcher of bus answers
  always @(posedge CLK) begin
    if (RESET_N && BVALID && BREADY) pop({30'h0, BRESP});
    if (RESET_N && RVALID && RREADY) pop(RDATA);
  end

  task temp(input int t);
    RTD_TEMP <= {16'(t), 16'(t)};
  endtask : temp

  task wait_heat(input logic v);
    n = 0;
    while (HEATER_ON !== v) begin
      @(posedge CLK);
      guard;
    end
    check("heater", {31'h0, HEATER_ON}, {31'h0, v});
  endtask : wait_heat

  task hi_count(input int c);
    k = 0;
    repeat (c) begin
      @(posedge CLK);
      k += (HEATER_ON === 1'b1);
    end
  endtask : hi_count

  initial begin
    seed = 32'h2ec9;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, GF_TRIP, HC_TRIP} = '0;
    {AWADDR, ARADDR, HEATER_AMPS, LEAK_MA} = '0;
    WDATA = '0;
    WSTRB = 4'hf;
    RTD_OHMS = {16'd100, 16'd100};
    RTD_TEMP = {16'd20, 16'd20};
    RESET_N = 1'b0;
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    rd(REG_CTRL, 32'h0, 32'h3);
    rd(REG_CLAMP, 32'h64, 32'h7f);
    rd(REG_MAINT, 32'h5, 32'hffff);
    rd(REG_MAXT, 32'hf, 32'hffff);
    rd(REG_MINAMB, 32'hffd8, 32'hffff);
    rd(REG_ADDR, 32'h1, 32'hff);
    rd(8'h40, 32'h0, '1);
    wr(8'h40, 32'h1);
    $display("test registers done");
    foreach (oh[i]) begin
      RTD_OHMS[15:0] <= 16'(oh[i]);
      repeat (2) @(posedge CLK);
      check("fault", 32'(RTD_FAULT[0]), 32'(i == 0 || i == 3));
      rd(REG_STATUS, (i == 0 || i == 3) ? 32'h100 : 32'h0, 32'h100);
    end
    RTD_OHMS[15:0] <= 16'd100;
    repeat (4) begin
      ta = $random(seed) % 40;
      tb = $random(seed) % 40;
      RTD_TEMP <= {16'(tb), 16'(ta)};
      rd(REG_TEMPS, {16'(ta > tb ? ta : tb), 16'(ta < tb ? ta : tb)}, '1);
      RTD_OHMS[31:16] <= 16'd400;
      rd(REG_TEMPS, {16'(ta), 16'(ta)}, '1);
      RTD_OHMS[31:16] <= 16'd100;
    end
    $display("test sensors done");
    temp(20);
    wait_heat(1'b0);
    temp(0);
    wait_heat(1'b1);
    temp(10);
    hi_count(900);
    check("band held on", k, 900);
    temp(15);
    wait_heat(1'b0);
    temp(10);
    hi_count(900);
    check("band held off", k, 0);
    temp(0);
    RTD_OHMS <= {16'd500, 16'd40};
    wait_heat(1'b0);
    hi_count(1200);
    check("no sensor off", k, 0);
    RTD_OHMS <= {16'd100, 16'd100};
    $display("test on off done");
    wr(REG_MAXT, 32'd100);
    foreach (md[i]) begin
      wr(REG_CTRL, 32'(md[i]));
      wr(REG_MAINT, md[i] == 3 ? 32'd40 : 32'd0);
      temp(tp[i]);
      rd(REG_STATUS, 32'(du[i]) << 24, 32'h7f1f0000);
    end
    $display("test proportional done");
    wr(REG_MAINT, 32'd5);
    wr(REG_MAXT, 32'd15);
    wr(REG_CTRL, 32'd1);
    wr(REG_CLAMP, 32'd20);
    temp(20);
    wait_heat(1'b0);
    temp(0);
    wait_heat(1'b1);
    k = 0;
    while (HEATER_ON === 1'b1 && k < 400) begin
      @(posedge CLK);
      k++;
    end
    check("soft duty", 32'(k >= 78 && k <= 88), 1);
    temp(20);
    wait_heat(1'b0);
    wr(REG_CLAMP, 32'd100);
    temp(0);
    wait_heat(1'b1);
    hi_count(800);
    check("clamp full", k, 800);
    $display("test soft start done");
    foreach (lk[i]) begin
      LEAK_MA <= 8'(lk[i]);
      HEATER_AMPS <= 8'(am[i]);
      {GF_TRIP, HC_TRIP} <= 2'b11;
      @(posedge CLK);
      {GF_TRIP, HC_TRIP} <= 2'b00;
      LEAK_MA <= 8'd99;
      HEATER_AMPS <= 8'd0;
      rd(REG_GFCAP, 32'(lx[i]), 32'hff);
      rd(REG_HCCAP, 32'(ax[i]), 32'hff);
    end
    $display("test trip capture done");
    wr(REG_CLEAR, 32'h3);
    HEATER_AMPS <= 8'd200;
    repeat (7300) @(posedge CLK);
    rd(REG_AHOUR, 32'h1, '1);
    rd(REG_WHOUR, 32'h0, 32'hfffffe00);
    check("watt hours", 32'(last >= 240 && last <= 270), 1);
    HEATER_AMPS <= 8'd0;
    wr(REG_CLEAR, 32'h1);
    rd(REG_AHOUR, 32'h0, '1);
    rd(REG_WHOUR, 32'h0, 32'hfffffe00);
    check("watt hours kept", 32'(last >= 240), 1);
    wr(REG_CLEAR, 32'h2);
    rd(REG_WHOUR, 32'h0, '1);
    $display("test totals done");
    tally_and_finish;
  end
endmodule : testbench
